// file: logic/rdl_edge_sync.sv
`timescale 1ns/100ps
module rdl_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic edge_pulse
);
  import rdl_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } rdl_sync_s;

  rdl_sync_s sync_reg;
  rdl_sync_s sync_next;

  // meta is read only by the second stage
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = din;
    sync_next.sync = sync_reg.meta;
    sync_next.last = sync_reg.sync;
    sync_next.pulse = sync_reg.sync ^ sync_reg.last;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign edge_pulse = sync_reg.pulse;

endmodule : rdl_edge_sync

// file: logic/rdl_lane_ctrl.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
// Contract
// - eq code: 00 none, 01 3.5dB, 1x 6dB
// - deemphasis code: 00 none, 01 3.5dB, 1x 6dB
// - enabled at power-up starts detection
// - trigger edge either way starts detection
// - standby and squelched while detecting
// - retry each channel until receiver found
// - after one find, three more tries other
// - found channel gets driver and idle detect
// - enable low keeps detection inactive
// - steady trigger level starts nothing
// - squelch below idle threshold, drive above
// - enable low shutdown, high normal
// - swing select 0 1000mV, 1 750mV
// - undriven inputs read as zero
module rdl_lane_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable,
  input wire logic detect_trigger,
  input wire logic eq_boost_msb_a,
  input wire logic eq_boost_lsb_a,
  input wire logic eq_boost_msb_b,
  input wire logic eq_boost_lsb_b,
  input wire logic deemph_sel_msb_a,
  input wire logic deemph_sel_lsb_a,
  input wire logic deemph_sel_msb_b,
  input wire logic deemph_sel_lsb_b,
  input wire logic swing_sel_ch_a,
  input wire logic swing_sel_ch_b,
  input wire logic rx_sense_a,
  input wire logic rx_sense_b,
  input wire logic idle_a,
  input wire logic idle_b,
  output rdl_pkg::rdl_level_e eq_level_a,
  output rdl_pkg::rdl_level_e eq_level_b,
  output rdl_pkg::rdl_level_e deemph_level_a,
  output rdl_pkg::rdl_level_e deemph_level_b,
  output logic swing_low_a,
  output logic swing_low_b,
  output logic standby,
  output logic detect_busy,
  output logic probe_a,
  output logic probe_b,
  output logic drv_en_a,
  output logic drv_en_b,
  output logic idle_det_en_a,
  output logic idle_det_en_b,
  output logic squelch_a,
  output logic squelch_b
);
  import rdl_pkg::*;

  typedef struct packed {
    rdl_state_e state;
    logic pwrup_pend;
    logic sw_start;
    logic [15:0] att_len;
    logic [15:0] att_cnt;
    logic found_a;
    logic found_b;
    logic [1:0] extra_cnt;
    rdl_level_e eq_a;
    rdl_level_e eq_b;
    rdl_level_e de_a;
    rdl_level_e de_b;
    logic swing_a;
    logic swing_b;
    logic standby;
    logic busy;
    logic probe_a;
    logic probe_b;
    logic drv_a;
    logic drv_b;
    logic squelch_a;
    logic squelch_b;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rdl_ctl_s;

  rdl_ctl_s ctl_reg;
  rdl_ctl_s ctl_next;
  logic trig_edge;
  logic start;
  logic at_end;
  logic hit_a;
  logic hit_b;

  // per-lane output decode, shared by both lanes
  typedef struct packed {
    logic probe;
    logic drv;
    logic squelch;
  } rdl_lane_out_s;

  rdl_lane_out_s out_a;
  rdl_lane_out_s out_b;

  function automatic rdl_lane_out_s rdl_lane_out(
    input rdl_state_e st,
    input logic found,
    input logic idle
  );
    rdl_lane_out_s o;
    o.probe = (st == RDL_DETECT) && !found;
    // a lane that never answered stays dark until the next start
    o.drv = (st == RDL_RUN) && found;
    o.squelch = !o.drv || idle;
    return o;
  endfunction : rdl_lane_out

  // a found lane stays found for the rest of the sequence
  function automatic logic rdl_hit(input logic found, input logic sense);
    return found || sense;
  endfunction : rdl_hit

  // status word as software sees it; enable is the live pin level
  function automatic logic [31:0] rdl_status_word(input rdl_ctl_s s, input logic en);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RDL_ST_STATE_LSB +: 2] = s.state;
    w[RDL_ST_FOUND_A_BIT] = s.found_a;
    w[RDL_ST_FOUND_B_BIT] = s.found_b;
    w[RDL_ST_EXTRA_LSB +: 2] = s.extra_cnt;
    w[RDL_ST_ENABLE_BIT] = en;
    w[RDL_ST_STANDBY_BIT] = s.standby;
    return w;
  endfunction : rdl_status_word

  function automatic logic [31:0] rdl_levels_word(input rdl_ctl_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RDL_LV_EQ_A_LSB +: 2] = s.eq_a;
    w[RDL_LV_EQ_B_LSB +: 2] = s.eq_b;
    w[RDL_LV_DE_A_LSB +: 2] = s.de_a;
    w[RDL_LV_DE_B_LSB +: 2] = s.de_b;
    w[RDL_LV_SWING_A_BIT] = s.swing_a;
    w[RDL_LV_SWING_B_BIT] = s.swing_b;
    return w;
  endfunction : rdl_levels_word

  rdl_edge_sync u_trig_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(detect_trigger),
    .edge_pulse(trig_edge)
  );

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.sw_start = 1'b0;
    ctl_next.pready = 1'b0;
    ctl_next.pslverr = 1'b0;
    // power-up request is only honoured on the first cycle after release
    ctl_next.pwrup_pend = 1'b0;

    // apb: one wait state so read data can come from a flop
    if (psel && penable && !ctl_reg.pready) begin
      ctl_next.pready = 1'b1;
      ctl_next.prdata = 32'h0000_0000;
      case (paddr)
        RDL_CTRL_OFS: begin
          ctl_next.prdata[RDL_CTRL_LEN_LSB +: 16] = ctl_reg.att_len;
        end
        RDL_STATUS_OFS: begin
          ctl_next.prdata = rdl_status_word(ctl_reg, enable);
        end
        RDL_LEVELS_OFS: begin
          ctl_next.prdata = rdl_levels_word(ctl_reg);
        end
        default: begin
          ctl_next.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && ctl_reg.pready && pwrite && paddr == RDL_CTRL_OFS) begin
      // a zero length would wrap to a 65536-cycle attempt
      if (pwdata[RDL_CTRL_LEN_LSB +: 16] == 16'h0000) begin
        ctl_next.att_len = 16'h0001;
      end else begin
        ctl_next.att_len = pwdata[RDL_CTRL_LEN_LSB +: 16];
      end
      ctl_next.sw_start = pwdata[RDL_CTRL_START_BIT];
    end

    // static strap decode, undriven pins decode as zero levels
    ctl_next.eq_a = rdl_decode_level(eq_boost_msb_a, eq_boost_lsb_a);
    ctl_next.eq_b = rdl_decode_level(eq_boost_msb_b, eq_boost_lsb_b);
    ctl_next.de_a = rdl_decode_level(deemph_sel_msb_a, deemph_sel_lsb_a);
    ctl_next.de_b = rdl_decode_level(deemph_sel_msb_b, deemph_sel_lsb_b);
    ctl_next.swing_a = swing_sel_ch_a;
    ctl_next.swing_b = swing_sel_ch_b;

    // only trigger edges, the software start bit or power-up start; a held level does nothing
    start = enable && (trig_edge || ctl_reg.sw_start || ctl_reg.pwrup_pend);
    at_end = (ctl_reg.att_cnt == 16'(ctl_reg.att_len - 16'h0001));
    hit_a = rdl_hit(ctl_reg.found_a, rx_sense_a);
    hit_b = rdl_hit(ctl_reg.found_b, rx_sense_b);

    if (!enable) begin
      // shutdown drops all detection progress
      ctl_next.state = RDL_OFF;
      ctl_next.att_cnt = 16'h0000;
      ctl_next.found_a = 1'b0;
      ctl_next.found_b = 1'b0;
      ctl_next.extra_cnt = 2'h0;
    end else if (start) begin
      ctl_next.state = RDL_DETECT;
      ctl_next.att_cnt = 16'h0000;
      ctl_next.found_a = 1'b0;
      ctl_next.found_b = 1'b0;
      ctl_next.extra_cnt = 2'h0;
    end else begin
      case (ctl_reg.state)
        RDL_OFF: begin
          ctl_next.state = RDL_OFF;
        end
        RDL_DETECT: begin
          if (at_end) begin
            ctl_next.att_cnt = 16'h0000;
            ctl_next.found_a = hit_a;
            ctl_next.found_b = hit_b;
            if (hit_a && hit_b) begin
              ctl_next.state = RDL_RUN;
            end else if (ctl_reg.found_a || ctl_reg.found_b) begin
              // count tries on the other channel after the first find
              ctl_next.extra_cnt = 2'(ctl_reg.extra_cnt + 2'h1);
              if (2'(ctl_reg.extra_cnt + 2'h1) == RDL_EXTRA_MAX) begin
                ctl_next.state = RDL_RUN;
              end
            end
            // no find at all: keep retrying without limit
          end else begin
            ctl_next.att_cnt = 16'(ctl_reg.att_cnt + 16'h0001);
          end
        end
        RDL_RUN: begin
          ctl_next.state = RDL_RUN;
        end
        default: begin
          ctl_next.state = RDL_OFF;
        end
      endcase
    end

    // outputs follow the next state so they change with it
    ctl_next.busy = (ctl_next.state == RDL_DETECT);
    ctl_next.standby = (ctl_next.state != RDL_RUN);
    out_a = rdl_lane_out(ctl_next.state, ctl_next.found_a, idle_a);
    out_b = rdl_lane_out(ctl_next.state, ctl_next.found_b, idle_b);
    ctl_next.probe_a = out_a.probe;
    ctl_next.probe_b = out_b.probe;
    ctl_next.drv_a = out_a.drv;
    ctl_next.drv_b = out_b.drv;
    ctl_next.squelch_a = out_a.squelch;
    ctl_next.squelch_b = out_b.squelch;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= '0;
      ctl_reg.state <= RDL_OFF;
      ctl_reg.pwrup_pend <= 1'b1;
      ctl_reg.att_len <= RDL_ATTEMPT_CYC;
      ctl_reg.standby <= 1'b1;
      ctl_reg.squelch_a <= 1'b1;
      ctl_reg.squelch_b <= 1'b1;
      ctl_reg.prdata <= RDL_PRDATA_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign prdata = ctl_reg.prdata;
  assign pready = ctl_reg.pready;
  assign pslverr = ctl_reg.pslverr;
  assign eq_level_a = ctl_reg.eq_a;
  assign eq_level_b = ctl_reg.eq_b;
  assign deemph_level_a = ctl_reg.de_a;
  assign deemph_level_b = ctl_reg.de_b;
  assign swing_low_a = ctl_reg.swing_a;
  assign swing_low_b = ctl_reg.swing_b;
  assign standby = ctl_reg.standby;
  assign detect_busy = ctl_reg.busy;
  assign probe_a = ctl_reg.probe_a;
  assign probe_b = ctl_reg.probe_b;
  assign drv_en_a = ctl_reg.drv_a;
  assign drv_en_b = ctl_reg.drv_b;
  assign idle_det_en_a = ctl_reg.drv_a;
  assign idle_det_en_b = ctl_reg.drv_b;
  assign squelch_a = ctl_reg.squelch_a;
  assign squelch_b = ctl_reg.squelch_b;

endmodule : rdl_lane_ctrl

// file: logic/rdl_pkg.sv
package rdl_pkg;

  // apb register map, byte addresses
  localparam logic [7:0] RDL_CTRL_OFS = 8'h00;
  localparam logic [7:0] RDL_STATUS_OFS = 8'h04;
  localparam logic [7:0] RDL_LEVELS_OFS = 8'h08;

  // ctrl fields
  localparam int RDL_CTRL_START_BIT = 0;
  localparam int RDL_CTRL_LEN_LSB = 16;

  // status fields
  localparam int RDL_ST_STATE_LSB = 0;
  localparam int RDL_ST_FOUND_A_BIT = 2;
  localparam int RDL_ST_FOUND_B_BIT = 3;
  localparam int RDL_ST_EXTRA_LSB = 4;
  localparam int RDL_ST_ENABLE_BIT = 6;
  localparam int RDL_ST_STANDBY_BIT = 7;

  // levels fields
  localparam int RDL_LV_EQ_A_LSB = 0;
  localparam int RDL_LV_EQ_B_LSB = 2;
  localparam int RDL_LV_DE_A_LSB = 4;
  localparam int RDL_LV_DE_B_LSB = 6;
  localparam int RDL_LV_SWING_A_BIT = 8;
  localparam int RDL_LV_SWING_B_BIT = 9;

  // timing: one detection attempt
  localparam int RDL_CLK_PERIOD_NS = 100;
  localparam int RDL_ATTEMPT_NS = 10000;
  localparam int RDL_ATTEMPT_CYC_INT = (RDL_ATTEMPT_NS / RDL_CLK_PERIOD_NS < 1) ? 1 :
                                       RDL_ATTEMPT_NS / RDL_CLK_PERIOD_NS;
  localparam logic [15:0] RDL_ATTEMPT_CYC = 16'(RDL_ATTEMPT_CYC_INT);

  // extra attempts on the other channel after the first find
  localparam logic [1:0] RDL_EXTRA_MAX = 2'h3;

  // reset values
  localparam logic [31:0] RDL_PRDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    RDL_LVL_0DB = 2'h0,
    RDL_LVL_3P5DB = 2'h1,
    RDL_LVL_6DB = 2'h2
  } rdl_level_e;

  // gray along off -> detect -> run
  typedef enum logic [1:0] {
    RDL_OFF = 2'h0,
    RDL_DETECT = 2'h1,
    RDL_RUN = 2'h3
  } rdl_state_e;

  // shared by equalization and deemphasis; msb set means top level
  function automatic rdl_level_e rdl_decode_level(input logic msb, input logic lsb);
    if (msb) begin
      return RDL_LVL_6DB;
    end else if (lsb) begin
      return RDL_LVL_3P5DB;
    end
    return RDL_LVL_0DB;
  endfunction : rdl_decode_level

endpackage : rdl_pkg

// file: tb/rdl_far_end.sv
`timescale 1ns/100ps
module rdl_far_end (
  input wire logic pclk,
  input wire logic probe_a,
  input wire logic probe_b,
  input wire logic present_a,
  input wire logic present_b,
  output logic rx_sense_a,
  output logic rx_sense_b
);
  logic junk_reg = 1'b0;
  // comparator means nothing unless probing, so it wanders
  always @(posedge pclk) junk_reg <= !junk_reg;
  assign rx_sense_a = probe_a ? present_a : junk_reg;
  assign rx_sense_b = probe_b ? present_b : !junk_reg;
endmodule : rdl_far_end

// file: tb/rdl_monitor.sv
`timescale 1ns/100ps
module rdl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic detect_trigger,
  input wire logic eq_boost_msb_a,
  input wire logic eq_boost_lsb_a,
  input wire logic deemph_sel_msb_b,
  input wire logic deemph_sel_lsb_b,
  input wire logic swing_sel_ch_a,
  input wire logic idle_a,
  input rdl_pkg::rdl_level_e eq_level_a,
  input rdl_pkg::rdl_level_e deemph_level_b,
  input wire logic swing_low_a,
  input wire logic standby,
  input wire logic detect_busy,
  input wire logic drv_en_a,
  input wire logic drv_en_b,
  input wire logic idle_det_en_a,
  input wire logic squelch_a
);
  import rdl_pkg::*;
  logic up_reg;
  // first edge after release still shows reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_toggle;
    enable && $changed(detect_trigger);
  endsequence
  property p_eq_a;
    up_reg |-> eq_level_a == ($past(eq_boost_msb_a) ? 2'h2 : {1'b0, $past(eq_boost_lsb_a)});
  endproperty
  a_eq_a: assert property (p_eq_a) else $error("eq level a wrong");
  property p_de_b;
    up_reg |-> deemph_level_b == ($past(deemph_sel_msb_b) ? 2'h2 : {1'b0, $past(deemph_sel_lsb_b)});
  endproperty
  a_de_b: assert property (p_de_b) else $error("deemph level b wrong");
  property p_swing;
    up_reg |-> swing_low_a == $past(swing_sel_ch_a);
  endproperty
  a_swing: assert property (p_swing) else $error("swing a wrong");
  property p_standby;
    detect_busy |-> standby && squelch_a && !drv_en_a && !drv_en_b;
  endproperty
  a_standby: assert property (p_standby) else $error("live while detecting");
  property p_off;
    !enable [*2] |-> !detect_busy && !drv_en_a && !drv_en_b && standby;
  endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  property p_drv_idle;
    (drv_en_a == idle_det_en_a) && (!$rose(drv_en_a) || $past(detect_busy));
  endproperty
  a_drv_idle: assert property (p_drv_idle) else $error("idle enable differs");
  property p_squelch;
    up_reg && $stable(idle_a) && idle_a == $past(idle_a, 2) |-> squelch_a == (!drv_en_a || idle_a);
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch a wrong");
  property p_trig;
    s_toggle |-> ##[1:6] (detect_busy || !enable);
  endproperty
  a_trig: assert property (p_trig) else $error("edge did not start");
endmodule : rdl_monitor
bind rdl_lane_ctrl rdl_monitor i_rdl_monitor (.*);

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rdl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, err, enable = 1'b1, detect_trigger = 1'b0;
  logic eq_boost_msb_a = 0, eq_boost_lsb_a = 0, eq_boost_msb_b = 0, eq_boost_lsb_b = 0;
  logic deemph_sel_msb_a = 0, deemph_sel_lsb_a = 0, deemph_sel_msb_b = 0, deemph_sel_lsb_b = 0;
  logic swing_sel_ch_a = 0, swing_sel_ch_b = 0, idle_a = 0, idle_b = 0;
  logic present_a = 1'b1, present_b = 1'b1, rx_sense_a, rx_sense_b;
  rdl_level_e eq_level_a, eq_level_b, deemph_level_a, deemph_level_b;
  logic swing_low_a, swing_low_b, standby, detect_busy, probe_a, probe_b;
  logic drv_en_a, drv_en_b, idle_det_en_a, idle_det_en_b, squelch_a, squelch_b;
  logic [3:0] a, b;
  int bad_count = 0, checks = 0, n;
  rdl_lane_ctrl i_rdl_lane_ctrl (.*);
  rdl_far_end i_rdl_far_end (.*);
  initial forever #50 pclk = !pclk;
  function automatic logic [1:0] lv(input logic [1:0] c);
    return c[1] ? 2'h2 : {1'b0, c[0]};
  endfunction : lv
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look mid-cycle so the edge that launches pready cannot race us
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    rd = prdata;
    err = pslverr;
    // release only after the edge at which pready is sampled high
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    while (detect_busy !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_busy
  task automatic report_and_stop();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #3000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cyc(3);
    chk({detect_busy, standby}, 2'b11);
    wait_busy(1'b0, 300);
    chk({drv_en_a, drv_en_b, idle_det_en_a, idle_det_en_b, standby}, 5'b11110);
    @(posedge pclk);
    idle_a <= 1'b1;
    cyc(3);
    chk({squelch_a, squelch_b}, 2'b10);
    @(posedge pclk);
    idle_a <= 1'b0;
    cyc(3);
    chk(squelch_a, 1'b0);
    for (int i = 0; i < 16; i++) begin
      a = 4'(i);
      b = 4'(15 - i);
      @(posedge pclk);
      {eq_boost_msb_a, eq_boost_lsb_a, deemph_sel_msb_a, deemph_sel_lsb_a} <= a;
      {eq_boost_msb_b, eq_boost_lsb_b, deemph_sel_msb_b, deemph_sel_lsb_b} <= b;
      {swing_sel_ch_b, swing_sel_ch_a} <= a[1:0];
      cyc(2);
      e = {22'h0, a[1:0], lv(b[1:0]), lv(a[1:0]), lv(b[3:2]), lv(a[3:2])};
      chk({swing_low_b, swing_low_a, deemph_level_b, deemph_level_a, eq_level_b, eq_level_a},
          e);
      apb(1'b0, RDL_LEVELS_OFS, 32'h0);
      chk(rd, e);
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    @(posedge pclk);
    enable <= 1'b0;
    cyc(3);
    chk({standby, drv_en_a, drv_en_b}, 3'b100);
    @(posedge pclk);
    detect_trigger <= 1'b1;
    // short attempts keep the retry scenarios brief
    apb(1'b1, RDL_CTRL_OFS, 32'h0004_0001);
    cyc(10);
    chk(detect_busy, 1'b0);
    @(posedge pclk);
    enable <= 1'b1;
    cyc(20);
    apb(1'b0, RDL_STATUS_OFS, 32'h0);
    chk({detect_busy, rd[7:0]}, 9'h0C0);
    @(posedge pclk);
    present_b <= 1'b0;
    detect_trigger <= 1'b0;
    wait_busy(1'b1, 10);
    chk(n <= 6, 1'b1);
    wait_busy(1'b0, 100);
    chk(n >= 14 && n <= 18, 1'b1);
    chk({drv_en_a, drv_en_b, squelch_b}, 3'b101);
    @(posedge pclk);
    present_a <= 1'b0;
    apb(1'b1, RDL_CTRL_OFS, 32'h0004_0001);
    cyc(200);
    chk({detect_busy, probe_a, probe_b, standby}, 4'hF);
    @(posedge pclk);
    present_b <= 1'b1;
    cyc(40);
    chk({detect_busy, drv_en_a, drv_en_b}, 3'b001);
    report_and_stop();
  end
endmodule : testbench
